//--- verilog/isd_pkg.sv
package isd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [11:0] ADDR_DESC_LO = 12'h000;
    localparam logic [11:0] ADDR_DESC_HI = 12'h004;
    localparam logic [11:0] ADDR_STATUS  = 12'h008;

    localparam logic [31:0] DESC_LO_RESET = 32'h0000_0000;
    localparam logic [31:0] DESC_HI_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // descriptor field positions, bit numbers within the 64-bit lower pair of words
    localparam int ADDR_MSB   = 41;
    localparam int ADDR_LSB   = 35;
    localparam int ENDP_MSB   = 34;
    localparam int ENDP_LSB   = 32;
    localparam int ENDP0_BIT  = 31;
    localparam int LIMIT_MSB  = 28;
    localparam int LIMIT_LSB  = 18;
    localparam int COUNT_MSB  = 17;
    localparam int COUNT_LSB  = 3;
    localparam int VALID_BIT  = 0;
    localparam int SPLIT_BIT  = 46;
    localparam int ACTIVE_BIT = 63;

    // status word layout
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_SPLIT_BIT  = 1;
    localparam int STAT_REMAIN_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ISD_IDLE  = 2'b01,
        ISD_ISSUE = 2'b10
    } isd_state_t;

    typedef struct packed {
        logic [6:0]  target_function_addr;
        logic [3:0]  endpoint_number;
        logic [10:0] translator_packet_limit;
        logic [14:0] total_byte_count;
        logic        split;
        logic        valid;
    } isd_fields_t;

    typedef struct packed {
        logic        valid;
        logic        split;
        logic        last;
        logic [6:0]  addr;
        logic [3:0]  endp;
        logic [14:0] len;
    } isd_token_t;

    // bytes carried by the next transaction
    function automatic logic [14:0] isd_chunk(input logic [14:0] remain,
                                              input logic [10:0] limit,
                                              input logic        split);
        logic [14:0] lim15;
        lim15 = {4'h0, limit};
        if (!split || limit == 11'h000 || remain <= lim15) begin
            return remain;
        end
        return lim15;
    endfunction

endpackage

//--- verilog/isd_field_decode.sv
`timescale 1ns/100ps
module isd_field_decode (
    input  wire logic [63:0]        desc_i,   // descriptor words one and zero
    output isd_pkg::isd_fields_t    fields_o  // decoded fields
);

    always_comb begin
        fields_o.target_function_addr    = desc_i[isd_pkg::ADDR_MSB:isd_pkg::ADDR_LSB];         // RULE_01
        fields_o.endpoint_number         = {desc_i[isd_pkg::ENDP_MSB:isd_pkg::ENDP_LSB],
                                            desc_i[isd_pkg::ENDP0_BIT]};                        // RULE_02
        fields_o.translator_packet_limit = desc_i[isd_pkg::LIMIT_MSB:isd_pkg::LIMIT_LSB];       // RULE_03
        fields_o.total_byte_count        = desc_i[isd_pkg::COUNT_MSB:isd_pkg::COUNT_LSB];       // RULE_06
        fields_o.split                   = desc_i[isd_pkg::SPLIT_BIT];                          // RULE_13
        fields_o.valid                   = desc_i[isd_pkg::VALID_BIT];
        // bits 30:29 and 2:1 are never looked at
    end                                                                                         // RULE_11

endmodule // isd_field_decode

//--- verilog/isd_split_engine.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - The target function address for tokens comes from descriptor bits 41 to 35.
// RULE_02 - The endpoint number is bits 34 to 32 on top with bit 31 as its lowest bit.
// RULE_03 - Each start split carries no more bytes than the 11-bit limit in bits 28 to 18; here a zero limit sends the whole remainder.
// RULE_04 - Software sets that limit to 188 out or 192 in when the millisecond total exceeds 188.
// RULE_05 - Otherwise software sets that limit equal to the millisecond total.
// RULE_06 - The 15-bit count in bits 17 to 3 sizes the data area of the descriptor.
// RULE_07 - Software keeps that count at 1023 or below.
// RULE_08 - The count doubles as the downstream maximum packet size, with no other size field.
// RULE_09 - Software sets the valid bit 0 when it has payload, making the descriptor active.
// RULE_10 - Hardware clears the valid bit when the descriptor is done or on a fatal error.
// RULE_11 - Bits 30 to 29 and 2 to 1 have no effect on operation.
// RULE_12 - Software writes active bit 63 equal to valid and hardware clears it later.
// RULE_13 - Bit 46 high selects a split transaction, low a plain high-speed one.
// RULE_14 - Nothing runs while valid is zero and clearing it leaves other fields untouched.
module isd_split_engine (
    input  wire logic               clock_i,    // 10 MHz clock
    input  wire logic               rst_b_i,    // async reset, active low
    input  wire logic               psel_i,     // apb select
    input  wire logic               penable_i,  // apb enable
    input  wire logic               pwrite_i,   // apb direction, high = write
    input  wire logic [11:0]        paddr_i,    // apb byte address
    input  wire logic [31:0]        pwdata_i,   // apb write data
    output logic      [31:0]        prdata_o,   // apb read data
    output logic                    pready_o,   // apb ready
    output logic                    pslverr_o,  // apb error, unmapped address
    output isd_pkg::isd_token_t     token_o,    // transaction request to the link
    input  wire logic               xact_done_i,// link finished the requested transaction
    input  wire logic               fatal_err_i // link reports a fatal error
);

    ////////////////////////////////////////////////////////////////////////
    // all state in one record: one process computes the next copy, one registers it
    typedef struct packed {
        isd_pkg::isd_state_t st;
        logic [31:0]         desc_lo;
        logic [31:0]         desc_hi;
        logic [14:0]         remain;
        logic [10:0]         limit;
        isd_pkg::isd_token_t tok;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } isd_regs_t;

    isd_regs_t            state_reg;
    isd_regs_t            state_next;
    isd_pkg::isd_fields_t fields;

    // decoding is combinational from the stored words; fields are latched only at start
    isd_field_decode u_decode (
        .desc_i   ({state_reg.desc_hi, state_reg.desc_lo}),
        .fields_o (fields)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic addr_known(input logic [11:0] a);
        return a == isd_pkg::ADDR_DESC_LO || a == isd_pkg::ADDR_DESC_HI || a == isd_pkg::ADDR_STATUS;
    endfunction

    // the status word is rebuilt every cycle, so a read always sees the live count
    function automatic logic [31:0] pack_status(input logic        is_busy,
                                                input logic        is_split,
                                                input logic [14:0] left);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[isd_pkg::STAT_BUSY_BIT]         = is_busy;
        w[isd_pkg::STAT_SPLIT_BIT]        = is_split;
        w[isd_pkg::STAT_REMAIN_LSB +: 15] = left;
        return w;
    endfunction

    // unmapped offsets read as zero; the error flag tells software why
    function automatic logic [31:0] read_mux(input logic [11:0] a,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi,
                                             input logic [31:0] stat);
        logic [31:0] w;
        case (a)
            isd_pkg::ADDR_DESC_LO: w = lo;
            isd_pkg::ADDR_DESC_HI: w = hi;
            isd_pkg::ADDR_STATUS:  w = stat;
            default:               w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // one place sizes a chunk, for the first one and for every later one
    // a zero limit, or a plain high-speed run, sends the whole remainder at once
    function automatic isd_pkg::isd_token_t size_chunk(input isd_pkg::isd_token_t cur,
                                                       input logic [14:0]         left,
                                                       input logic [10:0]         limit);
        isd_pkg::isd_token_t t;
        t      = cur;
        t.len  = isd_pkg::isd_chunk(left, limit, cur.split);                                    // RULE_03
        t.last = (t.len == left);
        return t;
    endfunction

    // only the two descriptor words take writes; the status offset drops them without an error
    function automatic logic [1:0] write_sel(input logic [11:0] a);
        logic [1:0] s;
        case (a)
            isd_pkg::ADDR_DESC_LO: s = 2'b01;
            isd_pkg::ADDR_DESC_HI: s = 2'b10;
            default:               s = 2'b00;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-cycle decisions shared by the engine and the bus slave
    logic        setup_phase;  // apb setup cycle
    logic        wr_commit;    // apb write lands at this edge
    logic        busy;         // a run is in progress
    logic        start_run;    // idle and software has set the valid bit
    logic        run_end;      // last chunk done, or a fatal error
    logic        chunk_step;   // a chunk before the last is done
    logic [1:0]  wr_sel;       // descriptor words written at this edge
    logic [14:0] left_after;   // bytes still owed once the current chunk is done
    logic [31:0] status_word;  // live status for reads
    logic [31:0] rd_word;      // read data picked at setup

    always_comb begin
        setup_phase = psel_i && !penable_i;
        wr_commit   = psel_i && penable_i && state_reg.pready && pwrite_i;
        busy        = (state_reg.st == isd_pkg::ISD_ISSUE);
        // a done or error pulse outside a run is ignored, so a stray link answer cannot start anything
        start_run   = (state_reg.st == isd_pkg::ISD_IDLE) && fields.valid;                       // RULE_14
        // fatal wins over done: the run stops whatever the link says about the chunk
        run_end     = busy && (fatal_err_i || (xact_done_i && state_reg.tok.last));              // RULE_10
        chunk_step  = busy && xact_done_i && !state_reg.tok.last && !fatal_err_i;
        left_after  = state_reg.remain - state_reg.tok.len;
        status_word = pack_status(busy, state_reg.tok.split, state_reg.remain);
        rd_word     = read_mux(paddr_i, state_reg.desc_lo, state_reg.desc_hi, status_word);

        // hold everything unless a branch below says otherwise
        state_next = state_reg;

        ////////////////////////////////////////////////////////////////////
        // transfer engine
        case (state_reg.st)
            isd_pkg::ISD_IDLE: begin
                // only a valid descriptor is ever started
                if (start_run) begin                                                             // RULE_14
                    state_next.st        = isd_pkg::ISD_ISSUE;
                    state_next.remain    = fields.total_byte_count;                              // RULE_06 RULE_08
                    // the limit is latched so a rewrite during the run cannot resize later chunks
                    state_next.limit     = fields.translator_packet_limit;                       // RULE_03
                    state_next.tok.valid = 1'b1;
                    state_next.tok.split = fields.split;                                         // RULE_13
                    state_next.tok.addr  = fields.target_function_addr;                          // RULE_01
                    state_next.tok.endp  = fields.endpoint_number;                               // RULE_02
                    state_next.tok       = size_chunk(state_next.tok, fields.total_byte_count,
                                                      fields.translator_packet_limit);           // RULE_03
                end
            end
            isd_pkg::ISD_ISSUE: begin
                if (run_end) begin
                    // only the two flag bits move; every other field keeps what software wrote
                    state_next.st                          = isd_pkg::ISD_IDLE;
                    state_next.tok.valid                   = 1'b0;
                    state_next.desc_lo[isd_pkg::VALID_BIT] = 1'b0;                              // RULE_10 RULE_14
                    state_next.desc_hi[isd_pkg::ACTIVE_BIT - 32] = 1'b0;
                    // a fatal error keeps the remaining count so software can see how far the run got
                    if (!fatal_err_i) begin
                        state_next.remain = 15'h0000;
                    end
                end else if (chunk_step) begin
                    // later chunks use the limit latched at start, not a mid-run rewrite
                    state_next.remain = left_after;
                    state_next.tok    = size_chunk(state_reg.tok, left_after, state_reg.limit);  // RULE_03
                end
            end
            default: begin
                // an illegal state code drops the request rather than guess at a run
                state_next.st        = isd_pkg::ISD_IDLE;
                state_next.tok.valid = 1'b0;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // apb slave: one wait-free access phase, ready registered from setup
        state_next.pready  = setup_phase;
        // an unmapped offset answers at once with the error flag, never with a stall
        state_next.pslverr = setup_phase && !addr_known(paddr_i);
        state_next.prdata  = 32'h0000_0000;
        // read data is taken at setup so that it already stands when pready rises
        if (setup_phase && !pwrite_i) begin
            state_next.prdata = rd_word;
        end

        // a software write lands after the hardware clear, so a set in the same cycle wins
        // the status offset takes no write, so only two selects exist
        wr_sel = wr_commit ? write_sel(paddr_i) : 2'b00;
        if (wr_sel[0]) begin
            state_next.desc_lo = pwdata_i;                                                       // RULE_09
        end
        if (wr_sel[1]) begin
            state_next.desc_hi = pwdata_i;                                                       // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset clears the record except the state, which loads ISD_IDLE, so the bus and the link see zeros until the first edge after release
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg         <= '0;
            state_reg.st      <= isd_pkg::ISD_IDLE;
            state_reg.desc_lo <= isd_pkg::DESC_LO_RESET;
            state_reg.desc_hi <= isd_pkg::DESC_HI_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output is a register bit, so no decode path reaches the pins
    assign prdata_o  = state_reg.prdata;
    assign pready_o  = state_reg.pready;
    assign pslverr_o = state_reg.pslverr;
    assign token_o   = state_reg.tok;

endmodule // isd_split_engine

//--- test/isd_split_engine_assertions.sv
`timescale 1ns/100ps
module isd_split_engine_assertions (
    input wire logic                clock_i, rst_b_i,                   // clock, async reset
    input wire logic                psel_i, penable_i, pwrite_i, pready_o, // apb handshake
    input wire logic [11:0]         paddr_i,                            // apb address
    input wire logic [31:0]         pwdata_i,                           // apb write data
    input wire logic                xact_done_i, fatal_err_i,           // link answers
    input wire isd_pkg::isd_token_t token_o                             // request to the link
);
    // shadow of software writes only; runs never overlap a write here, so no hw clear is tracked
    logic [63:0] desc_reg;
    logic        armed_reg;
    wire         wr_commit = psel_i && penable_i && pready_o && pwrite_i;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            desc_reg  <= 64'h0;
            armed_reg <= 1'b0;
        end else begin
            if (wr_commit && paddr_i == 12'h000) desc_reg[31:0] <= pwdata_i;
            if (wr_commit && paddr_i == 12'h004) desc_reg[63:32] <= pwdata_i;
            if (wr_commit && paddr_i == 12'h000) armed_reg <= pwdata_i[0];
            else if (token_o.valid) armed_reg <= 1'b0;
        end
    end
    ////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wait; token_o.valid && !xact_done_i && !fatal_err_i; endsequence
    sequence s_end; token_o.valid && (fatal_err_i || (xact_done_i && token_o.last)); endsequence
    a_token_hold: assert property (s_wait |=> $stable(token_o)) else $error("token moved");
    a_addr_field: assert property (token_o.valid |-> token_o.addr == desc_reg[41:35]) else $error("addr");
    a_endp_field: assert property (token_o.valid |-> token_o.endp == desc_reg[34:31]) else $error("endp");
    a_chunk_limit: assert property (token_o.valid && token_o.split && desc_reg[28:18] != 11'h0
        |-> token_o.len <= {4'h0, desc_reg[28:18]}) else $error("chunk too long");
    a_split_select: assert property (token_o.valid |-> token_o.split == desc_reg[46]) else $error("split");
    a_full_count: assert property (token_o.valid && !token_o.split
        |-> token_o.last && token_o.len == desc_reg[17:3]) else $error("plain length");
    a_valid_clear: assert property (s_end |=> !token_o.valid [*2]) else $error("run not ended");
    a_next_chunk: assert property (s_wait ##1 xact_done_i && !fatal_err_i && !token_o.last
        |=> token_o.valid) else $error("next chunk missing");
    a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o) else $error("ready not one cycle");
    a_start_armed: assert property ($rose(token_o.valid) |-> armed_reg) else $error("start unarmed");
endmodule // isd_split_engine_assertions

//--- test/isd_link_model.sv
`timescale 1ns/100ps
module isd_link_model (
    input  wire logic                clock_i,  // clock
    input  wire logic                rst_b_i,  // async reset, active low
    input  wire isd_pkg::isd_token_t token_i,  // request from the engine
    input  wire logic [3:0]          lat_i,    // cycles to wait before answering
    output logic                     done_o    // one-cycle completion pulse
);
    logic [3:0] wait_reg;
    // pulses only while a request stands, so a stray done never reaches an idle engine
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_reg <= 4'h0;
            done_o   <= 1'b0;
        end else if (token_i.valid && !done_o && wait_reg >= lat_i) begin
            wait_reg <= 4'h0;
            done_o   <= 1'b1;
        end else begin
            wait_reg <= token_i.valid ? wait_reg + 4'h1 : 4'h0;
            done_o   <= 1'b0;
        end
    end
endmodule // isd_link_model

//--- test/isd_split_engine_test.sv
`timescale 1ns/100ps
module isd_split_engine_test;
    logic                clock_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fatal = 1'b0;
    logic                pready, pslverr, done, e;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0, prdata, q;
    logic [3:0]          lat = 4'h0;
    isd_pkg::isd_token_t tok;
    int                  fails = 0, checked = 0;
    always #50 clock_i = ~clock_i;
    isd_split_engine dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .token_o(tok), .xact_done_i(done), .fatal_err_i(fatal));
    isd_link_model link_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .token_i(tok), .lat_i(lat), .done_o(done));
    ////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) fails++;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // reserved bits set on purpose, with valid and active written alike
    function automatic logic [63:0] mk(input logic sp, input logic [10:0] lim, input logic [14:0] cnt);
        mk = 64'h8000_0000_6000_0007;
        mk[46] = sp;
        mk[41:31] = {cnt[6:0] ^ 7'h55, lim[3:0] ^ 4'ha};
        mk[28:18] = lim;
        mk[17:3] = cnt;
    endfunction
    task automatic run(input logic [63:0] d, input logic [3:0] l);
        logic [14:0] rem, len;
        int n;
        lat <= l;
        apb(1'b1, 12'h004, d[63:32]);
        apb(1'b1, 12'h000, d[31:0]);
        rem = d[17:3];
        do begin
            len = (d[46] && d[28:18] != 11'h0 && rem > {4'h0, d[28:18]}) ? {4'h0, d[28:18]} : rem;
            n = 0;
            do @(posedge clock_i); while (!(tok.valid === 1'b1 && done === 1'b1) && ++n < 300);
            if (n >= 300) fails++;
            cmp({3'b000, tok}, {4'b0001, d[46], len == rem, d[41:31], len});
            rem = rem - len;
        end while (rem != 15'h0);
        @(posedge clock_i);
        cmp({31'h0, tok.valid}, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        cmp(q, d[31:0] & 32'hffff_fffe);
        cmp({31'h0, e}, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        cmp(q, d[63:32] & 32'h7fff_ffff);
        apb(1'b0, 12'h008, 32'h0);
        cmp(q, {30'h0, d[46], 1'b0});
    endtask
    ////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, 12'h004, 32'h0);
        cmp(q, isd_pkg::DESC_HI_RESET);
        apb(1'b0, 12'h00c, 32'h0);
        cmp({q[30:0], e}, 32'h1);
        apb(1'b1, 12'h008, 32'hffff_ffff);
        cmp({31'h0, e}, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        cmp(q, 32'h0);
        apb(1'b1, 12'h000, 32'h6000_0006);
        repeat (4) @(posedge clock_i);
        cmp({31'h0, tok.valid}, 32'h0);
    endtask
    task automatic t_chunks();
        run(mk(1'b1, 11'd188, 15'd400), 4'h0);
        run(mk(1'b1, 11'd192, 15'd400), 4'h2);
        run(mk(1'b1, 11'd150, 15'd150), 4'h1);
    endtask
    task automatic t_edges();
        run(mk(1'b0, 11'd188, 15'd1023), 4'h3);
        run(mk(1'b1, 11'd0, 15'd9), 4'h0);
        run(mk(1'b0, 11'd0, 15'd0), 4'h1);
    endtask
    task automatic t_fatal();
        logic [63:0] d;
        d = mk(1'b1, 11'd188, 15'd400);
        lat <= 4'hf;
        apb(1'b1, 12'h004, d[63:32]);
        apb(1'b1, 12'h000, d[31:0]);
        repeat (4) @(posedge clock_i);
        fatal <= 1'b1;
        @(posedge clock_i);
        fatal <= 1'b0;
        @(posedge clock_i);
        cmp({31'h0, tok.valid}, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        cmp(q, d[31:0] & 32'hffff_fffe);
        apb(1'b0, 12'h008, 32'h0);
        cmp(q, 32'h0190_0002);
    endtask
    task automatic conclude();
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_chunks();
        t_edges();
        t_fatal();
        conclude();
    end
    // the tests need a few hundred cycles; 50000 leaves wide margin
    initial begin
        #5_000_000;
        fails++;
        conclude();
    end
endmodule // isd_split_engine_test
bind isd_split_engine isd_split_engine_assertions chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .xact_done_i(xact_done_i), .fatal_err_i(fatal_err_i), .token_o(token_o));
